// [hdl/arf_pkg.sv]
package arf_pkg;
  // Architectural widths and special indices
  localparam int          XLEN        = 64;
  localparam int          NREG        = 32;
  localparam logic [4:0]  ZERO_IDX    = 5'h1f;
  localparam int          LIT_W       = 8;
  localparam int          PC_LSB      = 2;
  localparam logic [63:0] PC_STEP     = 64'h0000_0000_0000_0004;
  localparam logic [63:0] PC_RST      = 64'h0000_0000_0000_0000;
  localparam int          LW_SHIFT    = 2;
  localparam int          PF_SETS     = 2;
  localparam int          RD_PORTS    = 2;

  // Software register map (byte addresses)
  localparam logic [7:0]  CTRL_OFF    = 8'h00;
  localparam logic [7:0]  PCSET_LO    = 8'h04;
  localparam logic [7:0]  PCSET_HI    = 8'h08;
  localparam logic [7:0]  PC_LO_OFF   = 8'h0c;
  localparam logic [7:0]  PC_HI_OFF   = 8'h10;
  localparam logic [7:0]  STAT_OFF    = 8'h14;
  localparam logic [7:0]  LKA_LO_OFF  = 8'h18;
  localparam logic [7:0]  LKA_HI_OFF  = 8'h1c;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam int          CTRL_RUN    = 0;
  localparam int          STAT_LOCK   = 0;
  localparam int          STAT_INTR   = 1;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // Source operand request
  typedef struct packed {
    logic [4:0]       idx;
    logic             lit_en;
    logic [LIT_W-1:0] lit;
  } arf_rd_req_t;

  // Destination write request
  typedef struct packed {
    logic            en;
    logic [4:0]      idx;
    logic [XLEN-1:0] data;
  } arf_wr_req_t;

  // Reservation operation
  typedef struct packed {
    logic            ll;
    logic            sc;
    logic [XLEN-1:0] paddr;
  } arf_lock_op_t;
endpackage

// [hdl/arf_core.sv]
`timescale 1ns/1ps
`default_nettype none

module arf_core (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  // Decode and branch
  input  wire logic                    dec_valid,
  input  wire logic                    redirect_en,
  input  wire logic [63:0]             redirect_tgt,
  output logic [63:0]                  pc_q,
  // Operand reads
  input  wire arf_pkg::arf_rd_req_t    int_rd_req [arf_pkg::RD_PORTS],
  output logic [63:0]                  int_rd_data [arf_pkg::RD_PORTS],
  input  wire arf_pkg::arf_rd_req_t    fp_rd_req [arf_pkg::RD_PORTS],
  output logic [63:0]                  fp_rd_data [arf_pkg::RD_PORTS],
  // Result writes
  input  wire arf_pkg::arf_wr_req_t    int_wr,
  input  wire arf_pkg::arf_wr_req_t    fp_wr,
  // Address operand scaling
  input  wire logic [63:0]             disp_in,
  input  wire logic                    disp_lw_scale,
  output logic [63:0]                  disp_bytes,
  // Fetch exception
  input  wire logic                    fetch_exc_in,
  output logic                         fetch_exc_out,
  // Reservation
  input  wire arf_pkg::arf_lock_op_t   lock_op,
  output logic                         sc_ok,
  output logic                         lock_flag,
  output logic [63:0]                  lock_addr,
  // Interrupted-sequence flag
  input  wire logic                    read_then_clear_flag,
  input  wire logic                    read_then_set_flag,
  output logic                         intr_old,
  // Prefetch state
  input  wire logic                    pf_we,
  input  wire logic                    pf_set,
  input  wire logic [63:0]             pf_data,
  output logic [63:0]                  pf_state [arf_pkg::PF_SETS],
  // AXI4-Lite slave
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);
  import arf_pkg::*;

  // Merge a written word into a register under byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // True for every mapped software offset
  function automatic logic reg_hit(input logic [7:0] a);
    return (a == CTRL_OFF) || (a == PCSET_LO) || (a == PCSET_HI) || (a == PC_LO_OFF)
        || (a == PC_HI_OFF) || (a == STAT_OFF) || (a == LKA_LO_OFF) || (a == LKA_HI_OFF);
  endfunction

  // Architectural storage, one instance per processor
  logic [63:0]      int_rf [NREG];
  logic [63:0]      fp_rf  [NREG];
  logic [63:PC_LSB] pc_ff;
  logic             lock_flag_ff;
  logic [63:0]      lock_addr_ff;
  logic             intr_flag_ff;
  logic             intr_old_ff;
  logic             sc_ok_ff;
  logic             fexc_ff;
  logic [63:0]      disp_ff;
  logic [31:0]      ctrl_ff;
  logic [31:0]      pcset_lo_ff;
  logic [31:0]      pcset_hi_ff;

  // PC next value: software load when stopped, branch target, else step
  logic        run;
  logic        sw_pc_load;
  logic [31:0] pcset_hi_new;
  logic [63:0] pc_full;
  logic [63:0] nxt_pc;
  assign run     = ctrl_ff[CTRL_RUN];
  assign pc_full = {pc_ff, {PC_LSB{1'b0}}};
  assign pc_q    = pc_full;
  // The high word is taken as written this cycle, not the stale stored copy
  assign nxt_pc  = sw_pc_load  ? {pcset_hi_new, pcset_lo_ff}
                 : redirect_en ? redirect_tgt
                 : pc_full + PC_STEP;

  // Only the pipeline or a stopped-core load moves the PC
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc_ff <= PC_RST[63:PC_LSB];
    end else if (sw_pc_load || (run && (redirect_en || dec_valid))) begin
      pc_ff <= nxt_pc[63:PC_LSB];
    end
  end

  // Register writes; index 31 is never stored
  logic int_we;
  logic fp_we;
  assign int_we = int_wr.en && (int_wr.idx != ZERO_IDX);
  assign fp_we  = fp_wr.en && (fp_wr.idx != ZERO_IDX);

  // File arrays carry no reset, as a real file would not
  always_ff @(posedge clk) begin
    if (int_we) begin
      int_rf[int_wr.idx] <= int_wr.data;
    end
    if (fp_we) begin
      fp_rf[fp_wr.idx] <= fp_wr.data;
    end
  end

  // Read ports: one-cycle latency, read of a same-cycle write returns old data
  genvar gp;
  generate
    for (gp = 0; gp < RD_PORTS; gp++) begin : g_rd
      logic [63:0] nxt_int;
      logic [63:0] nxt_fp;
      logic [63:0] int_q_ff;
      logic [63:0] fp_q_ff;
      assign nxt_int = int_rd_req[gp].lit_en ? {{(64-LIT_W){1'b0}}, int_rd_req[gp].lit}
                     : (int_rd_req[gp].idx == ZERO_IDX) ? 64'h0000_0000_0000_0000
                     : int_rf[int_rd_req[gp].idx];
      assign nxt_fp  = (fp_rd_req[gp].idx == ZERO_IDX) ? 64'h0000_0000_0000_0000
                     : fp_rf[fp_rd_req[gp].idx];
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          int_q_ff <= 64'h0000_0000_0000_0000;
          fp_q_ff  <= 64'h0000_0000_0000_0000;
        end else begin
          int_q_ff <= nxt_int;
          fp_q_ff  <= nxt_fp;
        end
      end
      assign int_rd_data[gp] = int_q_ff;
      assign fp_rd_data[gp]  = fp_q_ff;
    end
  endgenerate

  // Address operand scaling and fetch exception pass-through
  logic [63:0] nxt_disp;
  assign nxt_disp = disp_lw_scale ? {disp_in[63-LW_SHIFT:0], {LW_SHIFT{1'b0}}} : disp_in;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      disp_ff <= 64'h0000_0000_0000_0000;
      fexc_ff <= 1'b0;
    end else begin
      disp_ff <= nxt_disp;
      fexc_ff <= fetch_exc_in;
    end
  end
  assign disp_bytes    = disp_ff;
  assign fetch_exc_out = fexc_ff;

  // Reservation: a new reservation beats a same-cycle clear
  logic nxt_lock_flag;
  assign nxt_lock_flag = lock_op.ll ? 1'b1
                       : (lock_op.sc ? 1'b0 : lock_flag_ff);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_flag_ff <= 1'b0;
      lock_addr_ff <= 64'h0000_0000_0000_0000;
      sc_ok_ff     <= 1'b0;
    end else begin
      lock_flag_ff <= nxt_lock_flag;
      sc_ok_ff     <= lock_op.sc && lock_flag_ff;
      if (lock_op.ll) begin
        lock_addr_ff <= lock_op.paddr;
      end
    end
  end
  assign sc_ok     = sc_ok_ff;
  assign lock_flag = lock_flag_ff;
  assign lock_addr = lock_addr_ff;

  // Interrupted-sequence flag; old value returned, set wins over clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      intr_flag_ff <= 1'b0;
      intr_old_ff  <= 1'b0;
    end else begin
      intr_old_ff <= intr_flag_ff;
      if (read_then_set_flag) begin
        intr_flag_ff <= 1'b1;
      end else if (read_then_clear_flag) begin
        intr_flag_ff <= 1'b0;
      end
    end
  end
  assign intr_old = intr_old_ff;

  // Prefetch state sets, reachable only from the pipeline
  genvar gs;
  generate
    for (gs = 0; gs < PF_SETS; gs++) begin : g_pf
      logic [63:0] pf_ff;
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          pf_ff <= 64'h0000_0000_0000_0000;
        end else if (pf_we && (pf_set == 1'(gs))) begin
          pf_ff <= pf_data;
        end
      end
      assign pf_state[gs] = pf_ff;
    end
  endgenerate

  // AXI write side: address and data taken independently, answer after both
  logic       aw_got_ff;
  logic       w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic       bvalid_ff;
  logic [1:0] bresp_ff;
  logic       aw_take;
  logic       w_take;
  logic       do_wr;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready  = !w_got_ff && !bvalid_ff;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign do_wr   = (aw_got_ff || aw_take) && (w_got_ff || w_take) && !bvalid_ff;
  assign wr_addr = aw_got_ff ? awaddr_ff : s_axi_awaddr;
  assign wr_data = w_got_ff ? wdata_ff : s_axi_wdata;
  assign wr_strb = w_got_ff ? wstrb_ff : s_axi_wstrb;
  assign pcset_hi_new = strb_merge(pcset_hi_ff, wr_data, wr_strb);
  // Loading the PC from software is only safe while the pipeline is stopped
  assign sw_pc_load = do_wr && (wr_addr == PCSET_HI) && !run;

  // Handshake state for the write channels
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else begin
      if (do_wr) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= reg_hit(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_got_ff <= 1'b1;
          awaddr_ff <= s_axi_awaddr;
        end
        if (w_take) begin
          w_got_ff <= 1'b1;
          wdata_ff <= s_axi_wdata;
          wstrb_ff <= s_axi_wstrb;
        end
        if (bvalid_ff && s_axi_bready) begin
          bvalid_ff <= 1'b0;
        end
      end
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // Writable software registers; status words ignore writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff     <= CTRL_RST;
      pcset_lo_ff <= 32'h0000_0000;
      pcset_hi_ff <= 32'h0000_0000;
    end else if (do_wr) begin
      if (wr_addr == CTRL_OFF) begin
        ctrl_ff <= strb_merge(ctrl_ff, wr_data, wr_strb) & 32'h0000_0001;
      end
      if (wr_addr == PCSET_LO) begin
        pcset_lo_ff <= strb_merge(pcset_lo_ff, wr_data, wr_strb) & 32'hffff_fffc;
      end
      if (wr_addr == PCSET_HI) begin
        pcset_hi_ff <= pcset_hi_new;
      end
    end
  end

  // AXI read side: one read at a time, answer one cycle after address
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] rd_mux;
  logic        ar_take;
  assign s_axi_arready = !rvalid_ff;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign rd_mux = (s_axi_araddr == CTRL_OFF)   ? ctrl_ff
                : (s_axi_araddr == PCSET_LO)   ? pcset_lo_ff
                : (s_axi_araddr == PCSET_HI)   ? pcset_hi_ff
                : (s_axi_araddr == PC_LO_OFF)  ? pc_full[31:0]
                : (s_axi_araddr == PC_HI_OFF)  ? pc_full[63:32]
                : (s_axi_araddr == STAT_OFF)   ? {30'h0000_0000, intr_flag_ff, lock_flag_ff}
                : (s_axi_araddr == LKA_LO_OFF) ? lock_addr_ff[31:0]
                : (s_axi_araddr == LKA_HI_OFF) ? lock_addr_ff[63:32]
                : 32'h0000_0000;

  // Read data held until the master takes it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

endmodule // arf_core

`default_nettype wire

// [testbench/arf_core_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// Port-level watcher for the register file
module arf_core_chk (
  input wire logic                 clk,
  input wire logic                 resetn,
  input wire logic                 dec_valid,
  input wire logic                 redirect_en,
  input wire logic [63:0]          pc_q,
  input wire arf_pkg::arf_rd_req_t int_rd_req [arf_pkg::RD_PORTS],
  input wire logic [63:0]          int_rd_data [arf_pkg::RD_PORTS],
  input wire arf_pkg::arf_rd_req_t fp_rd_req [arf_pkg::RD_PORTS],
  input wire logic [63:0]          fp_rd_data [arf_pkg::RD_PORTS],
  input wire logic [63:0]          disp_in,
  input wire logic                 disp_lw_scale,
  input wire logic [63:0]          disp_bytes,
  input wire logic                 fetch_exc_in,
  input wire logic                 fetch_exc_out,
  input wire arf_pkg::arf_lock_op_t lock_op,
  input wire logic                 sc_ok,
  input wire logic                 lock_flag,
  input wire logic [63:0]          lock_addr,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_awvalid
);
  import arf_pkg::*;
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  pc_align_a: assert property (pc_q[1:0] == 2'b00)
    else $error("pc low bits not zero");
  // A software load only lands while a write address or write data is offered
  pc_hold_a: assert property (
    !dec_valid && !redirect_en && !s_axi_wvalid && !s_axi_awvalid |=> $stable(pc_q))
    else $error("pc moved without a cause");
  pc_step_a: assert property (
    dec_valid && !redirect_en && !s_axi_wvalid && !s_axi_awvalid
    |=> pc_q == $past(pc_q) + PC_STEP || $stable(pc_q))
    else $error("pc step is not one instruction");
  fexc_pass_a: assert property (
    $past(resetn) |-> fetch_exc_out == $past(fetch_exc_in))
    else $error("fetch exception lost or late");
  disp_scale_a: assert property (
    $past(resetn) |-> disp_bytes == ($past(disp_lw_scale) ? $past(disp_in) << 2 : $past(disp_in)))
    else $error("address operand scaled wrongly");
  ll_record_a: assert property (
    lock_op.ll |=> lock_flag && lock_addr == $past(lock_op.paddr))
    else $error("reservation not recorded");
  sc_clear_a: assert property (
    lock_op.sc && !lock_op.ll |=> !lock_flag && sc_ok == $past(lock_flag))
    else $error("store-if-reserved outcome wrong");
  flag_keep_a: assert property (
    !lock_op.ll && !lock_op.sc |=> $stable(lock_flag) && !sc_ok)
    else $error("reservation flag changed idle");
  rst_flag_a: assert property ($rose(resetn) |-> !lock_flag)
    else $error("reservation flag set after reset");
  int_zero_a: assert property (
    int_rd_req[0].idx == ZERO_IDX && !int_rd_req[0].lit_en |=> int_rd_data[0] == '0)
    else $error("integer zero register not zero");
  fp_zero_a: assert property (
    fp_rd_req[0].idx == ZERO_IDX |=> fp_rd_data[0] == '0)
    else $error("float zero register not zero");
  lit_zext_a: assert property (
    int_rd_req[1].lit_en |=> int_rd_data[1] == 64'($past(int_rd_req[1].lit)))
    else $error("literal not zero extended");
endmodule // arf_core_chk

bind arf_core arf_core_chk u_chk (
  .clk(clk), .resetn(resetn), .dec_valid(dec_valid), .redirect_en(redirect_en),
  .pc_q(pc_q), .int_rd_req(int_rd_req), .int_rd_data(int_rd_data),
  .fp_rd_req(fp_rd_req), .fp_rd_data(fp_rd_data), .disp_in(disp_in),
  .disp_lw_scale(disp_lw_scale), .disp_bytes(disp_bytes), .fetch_exc_in(fetch_exc_in),
  .fetch_exc_out(fetch_exc_out), .lock_op(lock_op), .sc_ok(sc_ok),
  .lock_flag(lock_flag), .lock_addr(lock_addr), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_awvalid(s_axi_awvalid)
);
`default_nettype wire

// [testbench/arf_pipe_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Decode and execute side: operand reads, results, reservation ops
module arf_pipe_model (
  input  wire logic                  clk,
  output var arf_pkg::arf_rd_req_t   int_rd_req [arf_pkg::RD_PORTS],
  output var arf_pkg::arf_rd_req_t   fp_rd_req [arf_pkg::RD_PORTS],
  output var arf_pkg::arf_wr_req_t   int_wr,
  output var arf_pkg::arf_wr_req_t   fp_wr,
  output var arf_pkg::arf_lock_op_t  lock_op,
  input  wire logic [63:0]           int_rd_data [arf_pkg::RD_PORTS],
  input  wire logic [63:0]           fp_rd_data [arf_pkg::RD_PORTS]
);
  import arf_pkg::*;
  // Idle sources park on the zero index so the zero path is always exercised
  initial begin
    foreach (int_rd_req[p]) int_rd_req[p] = '{ZERO_IDX, 1'b0, 8'h00};
    foreach (fp_rd_req[p]) fp_rd_req[p] = '{ZERO_IDX, 1'b0, 8'h00};
    int_wr = '0;
    fp_wr = '0;
    lock_op = '0;
  end

  // One result write; released data is inverted so stale data never looks live
  task automatic wr(input bit fp, input logic [4:0] i, input logic [63:0] d);
    @(posedge clk);
    if (fp) fp_wr <= '{1'b1, i, d};
    else int_wr <= '{1'b1, i, d};
    @(posedge clk);
    int_wr <= '{1'b0, i, ~d};
    fp_wr <= '{1'b0, i, ~d};
  endtask

  // One operand read; data is registered one edge after the request
  task automatic rd(input bit fp, input int p, input logic [4:0] i, input logic le,
                    input logic [7:0] l, output logic [63:0] q);
    @(posedge clk);
    if (fp) fp_rd_req[p] <= '{i, le, l};
    else int_rd_req[p] <= '{i, le, l};
    @(posedge clk);
    int_rd_req[p] <= '{ZERO_IDX, 1'b0, ~l};
    fp_rd_req[p] <= '{ZERO_IDX, 1'b0, ~l};
    #1 q = fp ? fp_rd_data[p] : int_rd_data[p];
  endtask

  // Reservation ops carry no destination, so index 31 is never their target
  task automatic lock(input logic ll, input logic sc, input logic [63:0] a);
    @(posedge clk);
    lock_op <= '{ll, sc, a};
    @(posedge clk);
    lock_op <= '{1'b0, 1'b0, ~a};
    #1;
  endtask
endmodule // arf_pipe_model
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the architectural register file
module tb;
  import arf_pkg::*;
  `define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
  int           fails = 0;
  int           tests_run = 0;
  logic         clk = 1'b0, resetn = 1'b0, dec_valid = 1'b0, redirect_en = 1'b0;
  logic [63:0]  redirect_tgt = '0, disp_in = '0, pf_data = '0;
  logic         disp_lw_scale = 1'b0, fetch_exc_in = 1'b0, pf_we = 1'b0, pf_set = 1'b0;
  logic         read_then_clear_flag = 1'b0, read_then_set_flag = 1'b0;
  logic [7:0]   s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]  s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]   s_axi_wstrb = '0;
  logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [63:0]  pc_q, disp_bytes, lock_addr;
  logic [63:0]  int_rd_data [RD_PORTS], fp_rd_data [RD_PORTS], pf_state [PF_SETS];
  logic         fetch_exc_out, sc_ok, lock_flag, intr_old;
  arf_rd_req_t  int_rd_req [RD_PORTS], fp_rd_req [RD_PORTS];
  arf_wr_req_t  int_wr, fp_wr;
  arf_lock_op_t lock_op;
  logic [31:0]  d;
  logic [1:0]   r;
  logic [63:0]  q;

  arf_core DUT (
    .clk(clk), .resetn(resetn), .dec_valid(dec_valid), .redirect_en(redirect_en),
    .redirect_tgt(redirect_tgt), .pc_q(pc_q), .int_rd_req(int_rd_req),
    .int_rd_data(int_rd_data), .fp_rd_req(fp_rd_req), .fp_rd_data(fp_rd_data),
    .int_wr(int_wr), .fp_wr(fp_wr), .disp_in(disp_in), .disp_lw_scale(disp_lw_scale),
    .disp_bytes(disp_bytes), .fetch_exc_in(fetch_exc_in), .fetch_exc_out(fetch_exc_out),
    .lock_op(lock_op), .sc_ok(sc_ok), .lock_flag(lock_flag), .lock_addr(lock_addr),
    .read_then_clear_flag(read_then_clear_flag), .read_then_set_flag(read_then_set_flag),
    .intr_old(intr_old), .pf_we(pf_we), .pf_set(pf_set), .pf_data(pf_data),
    .pf_state(pf_state), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );
  arf_pipe_model pipe (
    .clk(clk), .int_rd_req(int_rd_req), .fp_rd_req(fp_rd_req), .int_wr(int_wr),
    .fp_wr(fp_wr), .lock_op(lock_op), .int_rd_data(int_rd_data), .fp_rd_data(fp_rd_data)
  );

  // 200 MHz
  always #2.5 clk = ~clk;

  // Bus write: both channels offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Bus read: no cycle count assumed, only the watchdog ends a wait
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic t_pc();
    axr(CTRL_OFF);
    `CHK("ctrl_rst", CTRL_RST, d)
    axw(PCSET_LO, 32'h0000_1003);
    axw(PCSET_HI, 32'h0000_0001);
    `CHK("pc_load", 64'h0000_0001_0000_1000, pc_q)
    axr(PC_LO_OFF);
    `CHK("pc_lo", 32'h0000_1000, d)
    axw(CTRL_OFF, 32'h0000_0001);
    @(posedge clk) dec_valid <= 1'b1;
    repeat (3) @(posedge clk);
    dec_valid <= 1'b0;
    #1 `CHK("pc_step", 64'h0000_0001_0000_100c, pc_q)
    @(posedge clk);
    redirect_tgt <= 64'h0000_0000_2000_0006;
    redirect_en <= 1'b1;
    dec_valid <= 1'b1;
    @(posedge clk);
    redirect_en <= 1'b0;
    dec_valid <= 1'b0;
    #1 `CHK("pc_jump", 64'h0000_0000_2000_0004, pc_q)
  endtask

  task automatic t_regs();
    pipe.wr(0, 5'h05, 64'hdead_beef_0123_4567);
    pipe.wr(0, ZERO_IDX, 64'hffff_ffff_ffff_ffff);
    pipe.wr(0, 5'h07, 64'h5555_aaaa_5555_aaaa);
    pipe.wr(1, 5'h07, 64'h4010_0000_1234_5678);
    pipe.wr(1, ZERO_IDX, 64'h3ff0_0000_0000_0000);
    pipe.rd(0, 0, 5'h05, 1'b0, 8'h00, q);
    `CHK("int_r5", 64'hdead_beef_0123_4567, q)
    pipe.rd(0, 0, ZERO_IDX, 1'b0, 8'h00, q);
    `CHK("int_zero", '0, q)
    pipe.rd(0, 1, 5'h05, 1'b1, 8'ha5, q);
    `CHK("int_lit", 64'h00a5, q)
    pipe.rd(1, 1, 5'h07, 1'b0, 8'h00, q);
    `CHK("fp_r7", 64'h4010_0000_1234_5678, q)
    pipe.rd(0, 1, 5'h07, 1'b0, 8'h00, q);
    `CHK("int_r7", 64'h5555_aaaa_5555_aaaa, q)
    pipe.rd(1, 0, ZERO_IDX, 1'b0, 8'h00, q);
    `CHK("fp_zero", '0, q)
    `CHK("pc_apart", 64'h0000_0000_2000_0004, pc_q)
  endtask

  task automatic t_lock();
    pipe.lock(1'b1, 1'b0, 64'h0000_00ab_cdef_0040);
    `CHK("lock_addr", 64'h0000_00ab_cdef_0040, lock_addr)
    axr(STAT_OFF);
    `CHK("stat_lock", 1'b1, d[STAT_LOCK])
    axr(LKA_HI_OFF);
    `CHK("lka_hi", 32'h0000_00ab, d)
    pipe.lock(1'b0, 1'b1, '0);
    `CHK("sc_ok", 1'b1, sc_ok)
    `CHK("flag_clr", 1'b0, lock_flag)
    pipe.lock(1'b0, 1'b1, '0);
    `CHK("sc_fail", 1'b0, sc_ok)
  endtask

  task automatic t_misc();
    @(posedge clk) read_then_clear_flag <= 1'b1;
    @(posedge clk);
    read_then_clear_flag <= 1'b0;
    read_then_set_flag <= 1'b1;
    @(posedge clk);
    read_then_set_flag <= 1'b0;
    read_then_clear_flag <= 1'b1;
    disp_in <= 64'h8000_0000_0000_0123;
    disp_lw_scale <= 1'b1;
    #1 `CHK("rs_old", 1'b0, intr_old)
    @(posedge clk);
    read_then_clear_flag <= 1'b0;
    disp_lw_scale <= 1'b0;
    fetch_exc_in <= 1'b1;
    #1 `CHK("rc_old", 1'b1, intr_old)
    `CHK("disp_lw", 64'h0000_0000_0000_048c, disp_bytes)
    @(posedge clk);
    fetch_exc_in <= 1'b0;
    pf_we <= 1'b1;
    pf_set <= 1'b1;
    pf_data <= 64'h0123_4567_89ab_cdef;
    #1 `CHK("disp_b", 64'h8000_0000_0000_0123, disp_bytes)
    `CHK("fexc", 1'b1, fetch_exc_out)
    @(posedge clk) pf_we <= 1'b0;
    #1 `CHK("pf_set1", 64'h0123_4567_89ab_cdef, pf_state[1])
    `CHK("pf_set0", 64'h0000_0000_0000_0000, pf_state[0])
    axr(8'h20);
    `CHK("hidden_r", RESP_SLVERR, r)
    axw(8'h20, 32'hffff_ffff);
    `CHK("hidden_w", RESP_SLVERR, r)
  endtask

  // A reservation left standing must not survive a reset
  task automatic t_rst();
    pipe.lock(1'b1, 1'b0, 64'h0000_0000_0000_0080);
    `CHK("rst_pre", 1'b1, lock_flag)
    @(posedge clk) resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1 `CHK("rst_flag", 1'b0, lock_flag)
  endtask

  task automatic give_verdict();
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_pc();
    t_regs();
    t_lock();
    t_misc();
    t_rst();
    give_verdict();
  end

  // Watchdog: the run needs under a hundred cycles, so 4000 is ample
  initial begin
    #20000;
    fails++;
    give_verdict();
  end
endmodule // tb
`default_nettype wire
